/* hw/lts_pkg.sv */
// Purpose: shared constants and types for the level triggered sampler
// Assumes: pclk at 10 MHz, audio sample strobe from the bus side
// Notes: all register offsets, the record level reset and cycle counts live here
package lts_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned FS_HZ = 48000;
   localparam int unsigned UNIT_MS_X100 = 136;
   localparam int unsigned UNIT_SAMPLES = FS_HZ * UNIT_MS_X100 / 100;
   localparam int unsigned FADE_MS = 5;
   localparam int unsigned FADE_SAMPLES = FS_HZ * FADE_MS / 1000;
   localparam int unsigned PRE_STD_MS = 5;
   localparam int unsigned PRE_EXP_MS = 2;
   localparam int unsigned PRE_STD_SAMPLES = FS_HZ * PRE_STD_MS / 1000;
   localparam int unsigned PRE_EXP_SAMPLES = FS_HZ * PRE_EXP_MS / 1000;
   localparam int unsigned LAT_STD_NS = 80000;
   localparam int unsigned LAT_FR_NS = 115000;
   localparam int unsigned LAT_STD_CYC = LAT_STD_NS / (1000000000 / CLK_HZ);
   localparam int unsigned LAT_FR_CYC = LAT_FR_NS / (1000000000 / CLK_HZ);
   localparam int unsigned HOLD_DUAL_MS = 100;
   localparam int unsigned HOLD_DUAL_CYC = HOLD_DUAL_MS * (CLK_HZ / 1000);
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LEVEL = 8'h04;
   localparam logic [7:0] REG_PLAY = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_KEYS = 8'h10;
   localparam logic [7:0] REG_EDIT = 8'h14;
   localparam logic [15:0] REC_LEVEL_RST = 16'h0800;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      LTS_STEREO, LTS_MONO, LTS_DUAL, LTS_FWDREV, LTS_EXP_STEREO, LTS_EXP_MONO
   } lts_variant_t;
   typedef enum logic [1:0] {LTS_TRIG_MANUAL, LTS_TRIG_LOOP, LTS_TRIG_LEVEL} lts_trig_t;
   typedef struct packed {
      logic [15:0] left;
      logic [15:0] right;
   } lts_audio_t;
endpackage

/* hw/lts_sampler.sv */
// Purpose: sampler record/capture and triggered playback engine
// Assumes: audio words arrive with a one-cycle sample strobe
// Notes: keys arrive as one-cycle pulses written over APB
// Overview of operation
// R1 - Memory sized in whole 1.36 s units at 48 kHz, 1.48 s at 44.1 kHz.
// R2 - Default capture trigger is left input above -24 dB.
// R3 - Pretrigger keeps 5 ms normally, zero for percussion variants.
// R4 - Expanded samplers keep 2 ms pretrigger audio.
// R5 - First capture any mode; later overdubs record immediately.
// R6 - Arm key starts continuous writing; snap key or level forces capture.
// R7 - Capturing shows remaining time, ready when post-trigger memory full.
// R8 - Mono records left only; stereo records both inputs, dual records the selected voice only.
// R9 - Fade type picks hard cut or 5 ms linear fade-in.
// R10 - Play starts one playback; play during playback restarts at head.
// R11 - Repeat count sampled at play trigger; stop key aborts repeats.
// R12 - Trigger mode manual, continuous loop, or left level threshold.
// R13 - Level and loop arm on play; stop key disarms them.
// R14 - Level play starts 80 us after crossing, 115 us forward/reverse.
// R15 - Level trigger re-arms after each triggered playback.
// R16 - Lockout default blocks retriggers; otherwise allowed after lockout.
// R17 - Dual rate-change always retriggers after fixed 100 ms lockout.
// R18 - Forward/reverse ignores level retriggers while playing.
// R19 - Stereo expanded rate from -100% to +199%.
// R20 - Mono expanded rate from -200% to +199%.
// R21 - Expanded play spans head to tail, swapped in reverse.
// R22 - Dual voice select picks recorded voice; voice 1 left, voice 2 right.
// R23 - Immediate mode records from arm until memory full.
// R24 - Offset zero keeps post-trigger only; at tail keeps pre-trigger only.
// R25 - Armed writing is circular so pretrigger audio survives.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lts_sampler #(
   parameter int UNITS = 1,
   parameter int UNIT_LEN = lts_pkg::UNIT_SAMPLES,
   parameter lts_pkg::lts_variant_t VARIANT = lts_pkg::LTS_STEREO,
   parameter bit PERC = 1'b0,
   parameter int HOLD_DUAL = lts_pkg::HOLD_DUAL_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   input wire lts_pkg::lts_audio_t audio_in,
   output lts_pkg::lts_audio_t audio_out,
   output logic capturing,
   output logic playing
);
   import lts_pkg::*;
   localparam int DEPTH = UNITS * UNIT_LEN; // [R1]
   localparam int AW = $clog2(DEPTH);
   // Pointer fields in the registers are 16 bits, so at most 65536 entries across all units
   if (UNITS < 1 || UNIT_LEN < 1 || DEPTH > 65536 || FADE_SAMPLES >= 2 ** AW) begin : g_bad_size
      $error("memory size not supported");
   end
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam bit EXPANDED = (VARIANT == LTS_EXP_STEREO) || (VARIANT == LTS_EXP_MONO);
   localparam bit STEREO_REC = (VARIANT == LTS_STEREO) || (VARIANT == LTS_DUAL)
      || (VARIANT == LTS_EXP_STEREO);
   localparam logic [AW-1:0] PRE_RST = PERC ? '0
      : AW'(EXPANDED ? PRE_EXP_SAMPLES : PRE_STD_SAMPLES); // [R3] [R4]
   localparam logic [13:0] LAT = 14'(VARIANT == LTS_FWDREV ? LAT_FR_CYC : LAT_STD_CYC);
   localparam logic signed [8:0] RMIN = (VARIANT == LTS_EXP_MONO) ? -9'sd200 : -9'sd100;
   localparam logic signed [8:0] RMAX = 9'sd199;

   // ************************************************************
   // Storage
   // ************************************************************
   lts_audio_t mem [DEPTH];
   typedef enum {ST_READY, ST_RECORDING, ST_CAPTURING} lts_rec_t;
   lts_rec_t rec_q;
   logic [AW-1:0] wptr_q, remain_q, trig_ptr_q, pre_q, head_q, tail_q;
   logic [15:0] rec_level_q, play_level_q;
   logic immediate_q, have_sample_q, perc_fade_q, voice_q;
   logic [1:0] mode_q;
   logic [7:0] repeat_set_q, repeats_q;
   logic [19:0] lockout_q, hold_cnt_q;
   logic signed [8:0] rate_q;
   logic [4:0] key_q;
   logic arm_key, snap_key, play_key, stop_key, aud_key;
   logic wr_en, rd_en;
   assign wr_en = psel && penable && pwrite;
   // Read data taken in setup so it stands through the access phase
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign {aud_key, stop_key, play_key, snap_key, arm_key} = key_q;
   logic [15:0] left_abs;
   assign left_abs = audio_in.left[15] ? 16'(-audio_in.left) : audio_in.left;

   // ************************************************************
   // APB registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_level_q <= REC_LEVEL_RST; // [R2]
         play_level_q <= REC_LEVEL_RST;
         immediate_q <= 1'b0;
         pre_q <= PRE_RST;
         perc_fade_q <= PERC;
         mode_q <= LTS_TRIG_MANUAL;
         repeat_set_q <= 8'h00;
         lockout_q <= 20'h00000; // [R16]
         rate_q <= 9'sd100;
         voice_q <= 1'b0;
         head_q <= '0;
         tail_q <= LAST;
         key_q <= 5'h00;
      end else begin
         key_q <= 5'h00;
         if (wr_en) begin
            if (paddr == REG_CTRL) begin
               immediate_q <= pwdata[0];
               perc_fade_q <= pwdata[1]; // [R9]
               voice_q <= pwdata[2];
               mode_q <= pwdata[5:4]; // [R12]
               repeat_set_q <= pwdata[15:8];
               // Lockout in steps of 16 cycles keeps it clear of the repeat field
               lockout_q <= {pwdata[31:16], 4'h0};
            end else if (paddr == REG_LEVEL) begin
               rec_level_q <= pwdata[15:0];
               play_level_q <= pwdata[31:16];
            end else if (paddr == REG_PLAY) begin
               if ($signed(pwdata[8:0]) < RMIN) rate_q <= RMIN; // [R19] [R20]
               else if ($signed(pwdata[8:0]) > RMAX) rate_q <= RMAX;
               else rate_q <= pwdata[8:0];
               pre_q <= pwdata[16 +: AW]; // [R24]
            end else if (paddr == REG_KEYS) begin
               key_q <= pwdata[4:0];
            end else if (paddr == REG_EDIT) begin
               head_q <= pwdata[0 +: AW];
               tail_q <= pwdata[16 +: AW];
            end
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pslverr <= 1'b0;
         if (rd_en) begin
            if (paddr == REG_CTRL) prdata <= {lockout_q[19:4], repeat_set_q, 2'b00, mode_q,
                                              1'b0, voice_q, perc_fade_q, immediate_q};
            else if (paddr == REG_LEVEL) prdata <= {play_level_q, rec_level_q};
            else if (paddr == REG_PLAY) prdata <= {16'(pre_q), 7'h00, rate_q};
            else if (paddr == REG_STATUS) prdata <= {16'(remain_q), 12'h000,
                     have_sample_q, playing, rec_q == ST_CAPTURING, rec_q == ST_RECORDING}; // [R7]
            else if (paddr == REG_EDIT) prdata <= {16'(tail_q), 16'(head_q)};
            else if (paddr == REG_KEYS) prdata <= 32'h00000000;
            else begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // Record and capture
   // ************************************************************
   logic lvl_rec_hit;
   assign lvl_rec_hit = sample_valid && !immediate_q && !have_sample_q
      && left_abs > rec_level_q; // [R2] [R5]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_q <= ST_READY;
         wptr_q <= '0;
         remain_q <= '0;
         trig_ptr_q <= '0;
         have_sample_q <= 1'b0;
      end else begin
         case (rec_q)
            ST_READY: begin
               if (arm_key) begin // [R6]
                  wptr_q <= '0;
                  if (immediate_q || have_sample_q) begin // [R5] [R23]
                     rec_q <= ST_CAPTURING;
                     remain_q <= LAST;
                  end else rec_q <= ST_RECORDING;
               end
            end
            ST_RECORDING: begin
               if (sample_valid) wptr_q <= (wptr_q == LAST) ? '0 : wptr_q + 1'b1; // [R25]
               if (snap_key || lvl_rec_hit) begin // [R6]
                  rec_q <= ST_CAPTURING;
                  remain_q <= LAST - pre_q; // [R24]
               end
            end
            ST_CAPTURING: begin
               if (sample_valid) begin
                  wptr_q <= (wptr_q == LAST) ? '0 : wptr_q + 1'b1;
                  if (remain_q == '0) begin // [R7]
                     rec_q <= ST_READY;
                     have_sample_q <= 1'b1;
                     trig_ptr_q <= (wptr_q == LAST) ? '0 : wptr_q + 1'b1;
                  end else remain_q <= remain_q - 1'b1;
               end
            end
            default: rec_q <= ST_READY;
         endcase
      end
   end
   always_ff @(posedge pclk) begin
      if (sample_valid && rec_q != ST_READY) begin
         if (VARIANT == LTS_DUAL) begin // [R22]
            if (voice_q) mem[wptr_q].right <= audio_in.right;
            else mem[wptr_q].left <= audio_in.left;
         end else begin
            mem[wptr_q].left <= audio_in.left;
            mem[wptr_q].right <= STEREO_REC ? audio_in.right : audio_in.left; // [R8]
         end
      end
   end
   assign capturing = (rec_q == ST_CAPTURING);

   // ************************************************************
   // Playback
   // ************************************************************
   logic armed_q, pend_q, hold_ok;
   logic [13:0] lat_q;
   logic [AW+7:0] pos_q;
   logic [AW-1:0] play_len_q, played_q, fade_q;
   logic lvl_play_hit, start;
   assign hold_ok = (VARIANT == LTS_DUAL) ? (hold_cnt_q >= 20'(HOLD_DUAL)) // [R17]
      : (VARIANT != LTS_FWDREV) && lockout_q != '0 && hold_cnt_q >= lockout_q; // [R16] [R18]
   assign lvl_play_hit = sample_valid && armed_q && mode_q == LTS_TRIG_LEVEL && !pend_q
      && left_abs > play_level_q && (!playing || hold_ok);
   assign start = play_key || (pend_q && lat_q == '0)
      || (armed_q && mode_q == LTS_TRIG_LOOP && !playing); // [R12]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
         pend_q <= 1'b0;
         lat_q <= '0;
         hold_cnt_q <= '0;
      end else begin
         if (play_key) armed_q <= 1'b1; // [R13]
         else if (stop_key) armed_q <= 1'b0;
         if (lvl_play_hit) begin // [R14]
            pend_q <= 1'b1;
            lat_q <= LAT - 1'b1;
         end else if (pend_q && lat_q != '0) lat_q <= lat_q - 1'b1;
         else pend_q <= 1'b0;
         if (start) hold_cnt_q <= '0;
         else if (hold_cnt_q != '1) hold_cnt_q <= hold_cnt_q + 1'b1;
      end
   end
   logic [AW-1:0] base;
   assign base = EXPANDED ? (rate_q < 0 ? tail_q : head_q)
      : AW'(({1'b0, trig_ptr_q} + {1'b0, head_q}) % DEPTH); // [R21]

   // ************************************************************
   // Play position
   // ************************************************************
   // Wraps around the buffer both ways, so reverse play never reads off its ends
   logic signed [AW+9:0] pos_nx;
   always_comb begin
      pos_nx = $signed({2'b00, pos_q}) + (AW+10)'(($signed(rate_q) * 256) / 100);
      if (pos_nx < 0) pos_nx = pos_nx + (AW+10)'(DEPTH * 256);
      else if (pos_nx >= (AW+10)'(DEPTH * 256)) pos_nx = pos_nx - (AW+10)'(DEPTH * 256);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         playing <= 1'b0;
         repeats_q <= '0;
         pos_q <= '0;
         played_q <= '0;
         play_len_q <= '0;
         fade_q <= '0;
         audio_out <= '0;
      end else begin
         if (start && have_sample_q) begin // [R10] [R15]
            playing <= 1'b1;
            repeats_q <= repeat_set_q; // [R11]
            pos_q <= {base, 8'h00};
            played_q <= '0;
            play_len_q <= EXPANDED ? (tail_q > head_q ? tail_q - head_q : head_q - tail_q)
                                   : LAST - head_q;
            fade_q <= perc_fade_q ? AW'(FADE_SAMPLES) : '0; // [R9]
         end else if (stop_key) begin
            playing <= 1'b0; // [R11]
            repeats_q <= '0;
         end else if (playing && sample_valid) begin
            pos_q <= pos_nx[AW+7:0]; // [R19] [R20]
            played_q <= played_q + 1'b1;
            if (fade_q != AW'(FADE_SAMPLES)) fade_q <= fade_q + 1'b1;
            if (played_q >= play_len_q) begin
               if (repeats_q != '0) begin
                  repeats_q <= repeats_q - 1'b1;
                  pos_q <= {base, 8'h00};
                  played_q <= '0;
               end else playing <= 1'b0;
            end
         end
         if (playing) begin
            audio_out.left <= 16'(($signed(mem[pos_q[AW+7:8]].left) * $signed({1'b0, fade_q}))
                                  / $signed(FADE_SAMPLES));
            audio_out.right <= 16'(($signed(mem[pos_q[AW+7:8]].right) * $signed({1'b0, fade_q}))
                                   / $signed(FADE_SAMPLES)); // [R22]
         end else audio_out <= '0;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_level_latency: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      lvl_play_hit |=> pend_q && lat_q == LAT - 14'd1) else $error("level hit not pended");
   a_latency_play: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      pend_q && lat_q == '0 && have_sample_q |=> playing) else $error("level play late");
   a_stop_disarm: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      stop_key && !play_key |=> !armed_q) else $error("stop did not disarm");
   a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      stop_key && !start |=> !playing && repeats_q == '0) else $error("stop did not halt");
   a_play_restart: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      play_key && have_sample_q |=> playing && played_q == '0) else $error("no restart");
   a_no_retrigger: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
      playing && lockout_q == '0 && VARIANT != LTS_DUAL |-> !lvl_play_hit)
      else $error("retrigger during lockout");
   a_pos_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
      pos_q[AW+7:8] <= LAST) else $error("play position off buffer");
   a_capture_done: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      capturing && sample_valid && remain_q == '0 |=> rec_q == ST_READY && have_sample_q)
      else $error("capture did not finish");
   a_arm_records: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      rec_q == ST_READY && arm_key && !immediate_q && !have_sample_q |=> rec_q == ST_RECORDING)
      else $error("arm did not record");
   a_overdub_immediate: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      rec_q == ST_READY && arm_key && have_sample_q |=> capturing)
      else $error("overdub waited");
   a_rate_range: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      rate_q >= RMIN && rate_q <= RMAX) else $error("rate out of range");
   a_repeat_load: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      start && have_sample_q && !stop_key |=> repeats_q == $past(repeat_set_q))
      else $error("repeat not sampled");
endmodule
`default_nettype wire

/* verification/lts_audio_src.sv */
// Purpose: audio source model feeding the sampler input stream
// Assumes: one sample strobe every PERIOD clocks
// Notes: data between strobes is scrambled so only strobed words count
`timescale 1ns/1ps
`default_nettype none
module lts_audio_src #(
   parameter int PERIOD = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] src_left,
   input wire logic [15:0] src_right,
   output logic sample_valid,
   output lts_pkg::lts_audio_t audio_in
);
   import lts_pkg::*;
   // ************************************************************
   // Sample stream
   // ************************************************************
   int cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         sample_valid <= 1'b0;
         audio_in <= '0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         sample_valid <= (cnt == PERIOD - 1);
         // Inverted between strobes: a design reading unstrobed data sees junk
         if (cnt == PERIOD - 1) begin
            audio_in <= {src_left, src_right};
         end else begin
            audio_in <= ~audio_in;
         end
      end
   end
endmodule
`default_nettype wire

/* verification/lts_sampler_tb.sv */
// Purpose: self-checking bench for the sampler engine
// Assumes: zero wait state APB slave, registered read data
// Notes: register rows first, then capture and playback cases
`timescale 1ns/1ps
`default_nettype none
module lts_sampler_tb;
   import lts_pkg::*;
   // ************************************************************
   // Signals
   // ************************************************************
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] m; logic e;} lts_row_t;
   localparam logic [15:0] LOUD = 16'h7000;
   localparam logic [15:0] QUIET = 16'h0100;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid;
   logic capturing, playing;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] src_left, src_right;
   lts_audio_t audio_in, audio_out;
   logic er;
   int n_errors, checks, n;
   lts_row_t rows [4];
   // Short memory keeps every capture run brief
   lts_sampler #(.UNITS(2), .UNIT_LEN(65), .HOLD_DUAL(50)) i_lts_sampler (.pclk(pclk),
      .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .audio_in(audio_in),
      .audio_out(audio_out), .capturing(capturing), .playing(playing));
   lts_audio_src #(.PERIOD(20)) i_lts_audio_src (.pclk(pclk), .presetn(presetn),
      .src_left(src_left), .src_right(src_right), .sample_valid(sample_valid),
      .audio_in(audio_in));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         k++;
         @(posedge pclk);
      end
      // Answer taken at the very edge that sees pready high
      if (k == 50) n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic key(input logic [4:0] k);
      apb(1'b1, REG_KEYS, {27'h0, k});
   endtask
   task automatic wait_out(input bit sel_play, input logic v, input int lim);
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while ((sel_play ? playing : capturing) !== v && n < lim);
      check({31'h0, sel_play ? playing : capturing}, {31'h0, v});
   endtask
   task automatic complete_run;
      if (n_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ************************************************************
   // Clock, watchdog
   // ************************************************************
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      // Whole run needs roughly 10k cycles
      repeat (40000) @(posedge pclk);
      n_errors++;
      complete_run;
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      src_left = QUIET;
      src_right = QUIET;
      n_errors = 0;
      checks = 0;
      rows[0] = '{REG_LEVEL, 32'h1234_0100, 32'hffff_ffff, 1'b0};
      rows[1] = '{REG_EDIT, 32'h0040_0008, 32'hffff_ffff, 1'b0};
      rows[2] = '{8'h18, 32'h5a5a_5a5a, 32'h0000_0000, 1'b1};
      rows[3] = '{8'hfc, 32'ha5a5_a5a5, 32'h0000_0000, 1'b1};
      repeat (19) @(posedge pclk);
      check({audio_out[31:2], capturing, playing}, 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_LEVEL, 32'h0);
      check({16'h0, rd[15:0]}, {16'h0, REC_LEVEL_RST});
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         check(rd & rows[i].m, rows[i].w & rows[i].m);
         check({31'h0, er}, {31'h0, rows[i].e});
      end
      apb(1'b1, REG_LEVEL, 32'h0800_0800);
      apb(1'b1, REG_CTRL, 32'h0000_0002);
      // First capture: loud right alone must not trigger
      key(5'h01);
      src_right <= LOUD;
      repeat (800) @(posedge pclk);
      #1;
      check({31'h0, capturing}, 32'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      check({31'h0, rd[0]}, 32'h1);
      src_left <= LOUD;
      wait_out(1'b0, 1'b1, 65);
      src_left <= QUIET;
      src_right <= QUIET;
      apb(1'b0, REG_STATUS, 32'h0);
      check({31'h0, rd[1]}, 32'h1);
      wait_out(1'b0, 1'b0, 4000);
      apb(1'b0, REG_STATUS, 32'h0);
      check({28'h0, rd[3:0]}, 32'h8);
      // Overdub records at once, even on a quiet input
      key(5'h01);
      wait_out(1'b0, 1'b1, 65);
      wait_out(1'b0, 1'b0, 4000);
      // Manual play, restart, stop
      key(5'h04);
      wait_out(1'b1, 1'b1, 200);
      repeat (40) @(posedge pclk);
      #1;
      check(audio_out, {QUIET, QUIET});
      repeat (260) @(posedge pclk);
      key(5'h04);
      #1;
      check({31'h0, playing}, 32'h1);
      key(5'h08);
      wait_out(1'b1, 1'b0, 200);
      // Level play: inert until armed by play
      apb(1'b1, REG_CTRL, 32'h0000_0022);
      src_left <= LOUD;
      repeat (200) @(posedge pclk);
      #1;
      check({31'h0, playing}, 32'h0);
      src_left <= QUIET;
      key(5'h04);
      wait_out(1'b1, 1'b0, 6000);
      src_left <= LOUD;
      do begin
         @(posedge pclk);
         #1;
      end while (!(sample_valid === 1'b1 && audio_in.left === LOUD));
      wait_out(1'b1, 1'b1, LAT_STD_CYC + 40);
      check({31'h0, (n >= LAT_STD_CYC - 20) && (n <= LAT_STD_CYC + 20)}, 32'h1);
      src_left <= QUIET;
      key(5'h08);
      wait_out(1'b1, 1'b0, 200);
      complete_run;
   end
endmodule
`default_nettype wire
